// ### logic/pbsc_map.svh
`ifndef PBSC_MAP_SVH
`define PBSC_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define PBSC_OFF_FAIL 8'hc4
`define PBSC_OFF_CTL01 8'hc8
`define PBSC_OFF_CTL23 8'hcc
`define PBSC_OFF_CTL45 8'hd0
`define PBSC_OFF_SWBRK 8'hdc
`define PBSC_OFF_INV 8'he8
`define PBSC_OFF_STS 8'hf0
`define PBSC_OFF_CLR 8'hf4
`define PBSC_OFF_IEN 8'hf8
// ==========================================
// System-fail enable fields
`define PBSC_FAIL_LOCKUP 3
`define PBSC_FAIL_BROWNOUT 1
`define PBSC_FAIL_CLOCK 0
`define PBSC_FAIL_MASK 32'h0000_000b
// ==========================================
// Pair control fields
`define PBSC_CTL_ODD_HI 19
`define PBSC_CTL_ODD_LO 18
`define PBSC_CTL_EVEN_HI 17
`define PBSC_CTL_EVEN_LO 16
`define PBSC_CTL_SYS_LVL 15
`define PBSC_CTL_P1_LVL 13
`define PBSC_CTL_P0_LVL 12
`define PBSC_CTL_SYS_EDGE 7
`define PBSC_CTL_P1_EDGE 5
`define PBSC_CTL_P0_EDGE 4
`define PBSC_CTL_MASK 32'h000f_b0b0
// ==========================================
// Software trigger, invert and interrupt fields
`define PBSC_SW_LVL_HI 10
`define PBSC_SW_LVL_LO 8
`define PBSC_INV_P0 0
`define PBSC_INV_P1 1
`define PBSC_STS_LVL_LO 0
`define PBSC_STS_EDGE_LO 3
`define PBSC_STS_WIDTH 6
`define PBSC_RESET_VAL 32'h0000_0000
`endif

// ### logic/pbsc_pair.sv
`include "pbsc_map.svh"
module pbsc_pair
  import pbsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] ctl,
  input wire logic sys_fail,
  input wire logic sys_rise,
  input wire logic p0_active,
  input wire logic p1_active,
  input wire logic p0_fall,
  input wire logic p1_fall,
  input wire logic sw_level,
  output logic edge_evt,
  output logic level_on,
  output logic [1:0] ovr,
  output logic [1:0] drv_en,
  output logic [1:0] drv_lvl
);
  logic edge_next;
  logic level_next;
  pbsc_act_t even_act;
  pbsc_act_t odd_act;

  // ==========================================
  // Source selection
  assign edge_next = (ctl[`PBSC_CTL_SYS_EDGE] & sys_rise)
    | (ctl[`PBSC_CTL_P1_EDGE] & p1_fall)
    | (ctl[`PBSC_CTL_P0_EDGE] & p0_fall);
  // Software trigger joins the level sources for one cycle
  assign level_next = (ctl[`PBSC_CTL_SYS_LVL] & sys_fail)
    | (ctl[`PBSC_CTL_P1_LVL] & p1_active)
    | (ctl[`PBSC_CTL_P0_LVL] & p0_active)
    | sw_level;
  assign even_act = pbsc_act_t'(ctl[`PBSC_CTL_EVEN_HI:`PBSC_CTL_EVEN_LO]);
  assign odd_act = pbsc_act_t'(ctl[`PBSC_CTL_ODD_HI:`PBSC_CTL_ODD_LO]);

  // Registered brake state
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_evt <= 1'b0;
      level_on <= 1'b0;
    end else begin
      edge_evt <= edge_next;
      level_on <= level_next;
    end
  end

  // Forced levels, only while the level brake holds
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr <= 2'b00;
      drv_en <= 2'b00;
      drv_lvl <= 2'b00;
    end else begin
      ovr[0] <= level_next & (even_act != PBSC_ACT_NONE);
      drv_en[0] <= even_act[1];
      drv_lvl[0] <= even_act == PBSC_ACT_HIGH;
      ovr[1] <= level_next & (odd_act != PBSC_ACT_NONE);
      drv_en[1] <= odd_act[1];
      drv_lvl[1] <= odd_act == PBSC_ACT_HIGH;
    end
  end

  // ==========================================
  // Checks
  sequence pin0_edge_s;
    ctl[`PBSC_CTL_P0_EDGE] && p0_fall;
  endsequence
  pin0_edge_a: assert property (@(posedge clk) disable iff (rst)
    pin0_edge_s |=> edge_evt)
    else $error("pin 0 fall with edge source on gave no edge brake");
  odd_tri_a: assert property (@(posedge clk) disable iff (rst)
    (level_next && odd_act == PBSC_ACT_TRI) |=> (ovr[1] && !drv_en[1]))
    else $error("odd channel not tri-stated during level brake");
  even_none_a: assert property (@(posedge clk) disable iff (rst)
    (even_act == PBSC_ACT_NONE) |=> !ovr[0])
    else $error("even channel overridden with no action selected");
endmodule // pbsc_pair

// ### logic/pbsc_pkg.sv
package pbsc_pkg;
  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    PBSC_BUS_IDLE = 2'b01,
    PBSC_BUS_ACK = 2'b10
  } pbsc_bus_t;
  // Level-brake action codes
  typedef enum logic [1:0] {
    PBSC_ACT_NONE = 2'b00,
    PBSC_ACT_TRI = 2'b01,
    PBSC_ACT_LOW = 2'b10,
    PBSC_ACT_HIGH = 2'b11
  } pbsc_act_t;
endpackage

// ### logic/pbsc_top.sv
// Decided for this implementation: the Wishbone register port.
`include "pbsc_map.svh"
module pbsc_top
  import pbsc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic protect_unlocked,
  input wire logic lockup_detect,
  input wire logic brownout_detect,
  input wire logic clock_fail_detect,
  input wire logic fault_input_0,
  input wire logic fault_input_1,
  output logic [2:0] edge_brake,
  output logic [2:0] level_brake,
  output logic [5:0] chan_override,
  output logic [5:0] chan_drive_en,
  output logic [5:0] chan_level,
  output logic irq
);
  // ==========================================
  // Declarations
  pbsc_bus_t bus_reg;
  pbsc_bus_t bus_next;
  logic [31:0] fail_reg;
  logic [31:0] ctl_reg [3];
  logic [1:0] inv_reg;
  logic [`PBSC_STS_WIDTH-1:0] sts_reg;
  logic [`PBSC_STS_WIDTH-1:0] ien_reg;
  logic [`PBSC_STS_WIDTH-1:0] sts_set;
  logic [`PBSC_STS_WIDTH-1:0] sts_clr;
  logic [2:0] sw_lvl_reg;
  logic [31:0] wmask;
  logic [31:0] rdata;
  logic take;
  logic wr;
  logic sys_fail;
  logic sys_fail_d;
  logic sys_rise;
  logic [1:0] pin_eff;
  logic [1:0] pin_d;
  logic [1:0] pin_fall;

  // ==========================================
  // Wishbone slave
  // Request taken in idle; ack follows one cycle later
  assign take = wb_cyc_i & wb_stb_i & (bus_reg == PBSC_BUS_IDLE);
  assign wr = take & wb_we_i;
  assign wb_ack_o = bus_reg == PBSC_BUS_ACK;

  // Byte-lane mask from select lines
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // Handshake state
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      PBSC_BUS_IDLE: begin
        if (take) begin
          bus_next = PBSC_BUS_ACK;
        end
      end
      PBSC_BUS_ACK: begin
        bus_next = PBSC_BUS_IDLE;
      end
      default: begin
        bus_next = PBSC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_reg <= PBSC_BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Read mux; unmapped and write-only words read zero
  always_comb begin
    rdata = `PBSC_RESET_VAL;
    unique case (wb_adr_i)
      `PBSC_OFF_FAIL: rdata = fail_reg;
      `PBSC_OFF_CTL01: rdata = ctl_reg[0];
      `PBSC_OFF_CTL23: rdata = ctl_reg[1];
      `PBSC_OFF_CTL45: rdata = ctl_reg[2];
      `PBSC_OFF_INV: rdata = {30'h0, inv_reg};
      `PBSC_OFF_STS: rdata = {26'h0, sts_reg};
      `PBSC_OFF_IEN: rdata = {26'h0, ien_reg};
      default: rdata = `PBSC_RESET_VAL;
    endcase
  end

  // Read data captured with the request, held through ack
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= `PBSC_RESET_VAL;
    end else if (take) begin
      wb_dat_o <= wb_we_i ? `PBSC_RESET_VAL : rdata;
    end
  end

  // ==========================================
  // Configuration registers
  // Fail enable is not write protected
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_reg <= `PBSC_RESET_VAL;
    end else if (wr && wb_adr_i == `PBSC_OFF_FAIL) begin
      fail_reg <= (fail_reg & ~wmask)
        | (wb_dat_i & wmask & `PBSC_FAIL_MASK);
    end
  end

  // Pair control words; a locked write is acked but dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < 3; p++) begin
        ctl_reg[p] <= `PBSC_RESET_VAL;
      end
    end else if (wr && protect_unlocked) begin
      for (int p = 0; p < 3; p++) begin
        if (wb_adr_i == `PBSC_OFF_CTL01 + 8'(p * 4)) begin
          ctl_reg[p] <= (ctl_reg[p] & ~wmask)
            | (wb_dat_i & wmask & `PBSC_CTL_MASK);
        end
      end
    end
  end

  // Fault input polarity
  always_ff @(posedge clk) begin
    if (rst) begin
      inv_reg <= 2'b00;
    end else if (wr && wb_adr_i == `PBSC_OFF_INV && wb_sel_i[0]) begin
      inv_reg <= wb_dat_i[`PBSC_INV_P1:`PBSC_INV_P0];
    end
  end

  // Software level trigger: one-cycle pulse, write protected
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_lvl_reg <= 3'b000;
    end else if (wr && protect_unlocked && wb_adr_i == `PBSC_OFF_SWBRK
                 && wb_sel_i[1]) begin
      sw_lvl_reg <= wb_dat_i[`PBSC_SW_LVL_HI:`PBSC_SW_LVL_LO];
    end else begin
      sw_lvl_reg <= 3'b000;
    end
  end

  // ==========================================
  // Fault sources
  // Detector inputs are used as levels; masked before the OR
  assign sys_fail = (fail_reg[`PBSC_FAIL_LOCKUP] & lockup_detect)
    | (fail_reg[`PBSC_FAIL_BROWNOUT] & brownout_detect)
    | (fail_reg[`PBSC_FAIL_CLOCK] & clock_fail_detect);

  // Inversion before the edge detector, so a high-active fault works too
  assign pin_eff = {fault_input_1 ^ inv_reg[1], fault_input_0 ^ inv_reg[0]};

  // Edge detection history
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_fail_d <= 1'b0;
      pin_d <= 2'b11;
    end else begin
      sys_fail_d <= sys_fail;
      pin_d <= pin_eff;
    end
  end

  assign sys_rise = sys_fail & ~sys_fail_d;
  assign pin_fall = pin_d & ~pin_eff;

  // ==========================================
  // Per-pair brake logic
  for (genvar p = 0; p < 3; p++) begin : g_pair
    pbsc_pair u_pair (
      .clk(clk),
      .rst(rst),
      .ctl(ctl_reg[p]),
      .sys_fail(sys_fail),
      .sys_rise(sys_rise),
      .p0_active(~pin_eff[0]),
      .p1_active(~pin_eff[1]),
      .p0_fall(pin_fall[0]),
      .p1_fall(pin_fall[1]),
      .sw_level(sw_lvl_reg[p]),
      .edge_evt(edge_brake[p]),
      .level_on(level_brake[p]),
      .ovr(chan_override[2*p +: 2]),
      .drv_en(chan_drive_en[2*p +: 2]),
      .drv_lvl(chan_level[2*p +: 2])
    );
  end

  // ==========================================
  // Interrupt status
  assign sts_set = {edge_brake, level_brake};
  assign sts_clr = (wr && wb_adr_i == `PBSC_OFF_CLR && wb_sel_i[0])
    ? wb_dat_i[`PBSC_STS_WIDTH-1:0] : 6'h00;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_reg <= 6'h00;
    end else begin
      sts_reg <= (sts_reg & ~sts_clr) | sts_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ien_reg <= 6'h00;
    end else if (wr && wb_adr_i == `PBSC_OFF_IEN && wb_sel_i[0]) begin
      ien_reg <= wb_dat_i[`PBSC_STS_WIDTH-1:0];
    end
  end

  // Level output straight from the flags
  assign irq = |(sts_reg & ien_reg);

  // ==========================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence locked_ctl_write_s;
    wr && !protect_unlocked && wb_adr_i == `PBSC_OFF_CTL01;
  endsequence
  sequence sw_trig_s;
    wr && protect_unlocked && wb_adr_i == `PBSC_OFF_SWBRK
      && wb_sel_i[1] && wb_dat_i[`PBSC_SW_LVL_LO];
  endsequence

  locked_write_hold_a: assert property (
    locked_ctl_write_s |=> $stable(ctl_reg[0]))
    else $error("pair control changed while protection locked");
  sw_level_flag_a: assert property (
    sw_trig_s |=> ##1 level_brake[0] ##1 sts_reg[`PBSC_STS_LVL_LO])
    else $error("software trigger gave no level brake and flag");
  lockup_off_a: assert property (
    !fail_reg[`PBSC_FAIL_LOCKUP] && !brownout_detect && !clock_fail_detect
      |-> !sys_fail)
    else $error("system fail raised with no enabled source");
  brownout_on_a: assert property (
    fail_reg[`PBSC_FAIL_BROWNOUT] && brownout_detect |-> sys_fail)
    else $error("enabled brown-out did not raise system fail");
  clock_fail_a: assert property (
    fail_reg[`PBSC_FAIL_CLOCK] && clock_fail_detect |-> sys_fail)
    else $error("enabled clock failure did not raise system fail");
  sys_edge_a: assert property (
    ctl_reg[2][`PBSC_CTL_SYS_EDGE] && $rose(sys_fail) |=> edge_brake[2])
    else $error("system fail rise gave no edge brake on pair 4/5");
  pin1_level_a: assert property (
    !ctl_reg[2][`PBSC_CTL_P1_LVL] && !ctl_reg[2][`PBSC_CTL_P0_LVL]
      && !ctl_reg[2][`PBSC_CTL_SYS_LVL] && !sw_lvl_reg[2] |=> !level_brake[2])
    else $error("pair 4/5 level brake without any source");
  pin_fall_a: assert property (
    $fell(pin_eff[0]) |-> pin_fall[0])
    else $error("falling fault input 0 not detected");
  ack_one_a: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  irq_level_a: assert property (
    (sts_reg & ien_reg) != 6'h00 |-> irq)
    else $error("interrupt low with enabled flag set");

  // Enabled sources must reach their brake, disabled ones must not
  lockup_on_a: assert property (
    fail_reg[`PBSC_FAIL_LOCKUP] && lockup_detect |-> sys_fail)
    else $error("enabled lockup did not raise system fail");
  brownout_off_a: assert property (
    !fail_reg[`PBSC_FAIL_BROWNOUT] && !lockup_detect && !clock_fail_detect
      |-> !sys_fail)
    else $error("system fail raised by a disabled brown-out");
  clock_off_a: assert property (
    !fail_reg[`PBSC_FAIL_CLOCK] && !lockup_detect && !brownout_detect
      |-> !sys_fail)
    else $error("system fail raised by a disabled clock failure");
  sys_level_a: assert property (
    ctl_reg[2][`PBSC_CTL_SYS_LVL] && sys_fail |=> level_brake[2])
    else $error("system fail with level source on gave no level brake");
  pin1_level_on_a: assert property (
    ctl_reg[1][`PBSC_CTL_P1_LVL] && !pin_eff[1] |=> level_brake[1])
    else $error("low fault input 1 gave no level brake on pair 2/3");
  pin0_level_a: assert property (
    ctl_reg[0][`PBSC_CTL_P0_LVL] && !pin_eff[0] |=> level_brake[0])
    else $error("low fault input 0 gave no level brake on pair 0/1");
  pin1_edge_a: assert property (
    ctl_reg[1][`PBSC_CTL_P1_EDGE] && pin_fall[1] |=> edge_brake[1])
    else $error("fault input 1 fall gave no edge brake on pair 2/3");

  // A full-word unlocked write lands, masked to the defined fields
  ctl_write_a: assert property (
    wr && protect_unlocked && wb_adr_i == `PBSC_OFF_CTL01 && wb_sel_i == 4'hf
      |=> ctl_reg[0] == ($past(wb_dat_i) & `PBSC_CTL_MASK))
    else $error("unlocked pair control write did not land");
  sw_locked_a: assert property (
    wr && !protect_unlocked && wb_adr_i == `PBSC_OFF_SWBRK |=> sw_lvl_reg == 3'h0)
    else $error("software trigger accepted while protection locked");

  // Set wins, so a brake event is never lost to a clear in the same cycle
  sts_set_a: assert property (
    sts_set != 6'h00 |=> (sts_reg & $past(sts_set)) == $past(sts_set))
    else $error("status flag missed its brake event");
  sts_clear_a: assert property (
    sts_clr[3] && !sts_set[3] |=> !sts_reg[3])
    else $error("edge flag of pair 0/1 not cleared");
  irq_low_a: assert property (
    (sts_reg & ien_reg) == 6'h00 |-> !irq)
    else $error("interrupt high with no enabled flag set");
  // Read data is captured with the request and stands through ack
  read_data_a: assert property (
    take && !wb_we_i |=> wb_dat_o == $past(rdata))
    else $error("read data not the addressed register");
endmodule // pbsc_top

// ### tb/pbsc_fault_model.sv
// ==========================================
// Power stage fault pins and system detectors
module pbsc_fault_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] req,
  output logic fault_input_0,
  output logic fault_input_1,
  output logic lockup_detect,
  output logic brownout_detect,
  output logic clock_fail_detect
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle high, a fault pulls low; registered so edges land after clk
  always_ff @(posedge clk) begin
    fault_input_0 <= rst | ~req[0];
    fault_input_1 <= rst | ~req[1];
    lockup_detect <= ~rst & req[2];
    brownout_detect <= ~rst & req[3];
    clock_fail_detect <= ~rst & req[4];
  end
endmodule // pbsc_fault_model

// ### tb/pbsc_top_bench.sv
`include "pbsc_map.svh"
module pbsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pbsc_pkg::*;
  // ==========================================
  // Signals
  logic clk, rst, cyc, stb, we, unl;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rd, wb_dat_o;
  logic [4:0] req;
  logic wb_ack_o, irq, f0, f1, lk, bo, cf;
  logic [2:0] edge_brake, level_brake;
  logic [5:0] chan_override, chan_drive_en, chan_level;
  int failures, compares;
  pbsc_top dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .protect_unlocked(unl), .lockup_detect(lk),
    .brownout_detect(bo), .clock_fail_detect(cf), .fault_input_0(f0),
    .fault_input_1(f1), .edge_brake(edge_brake), .level_brake(level_brake),
    .chan_override(chan_override), .chan_drive_en(chan_drive_en),
    .chan_level(chan_level), .irq(irq));
  pbsc_fault_model far_u (.clk(clk), .rst(rst), .req(req), .fault_input_0(f0),
    .fault_input_1(f1), .lockup_detect(lk), .brownout_detect(bo),
    .clock_fail_detect(cf));
  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim;
  end
  // ==========================================
  // Tasks
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; held until ack is sampled, no fixed latency assumed
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      end_sim;
    end else begin
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk($sformatf("reg %h", a), rd, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task setq(input logic [4:0] r);
    @(posedge clk);
    req <= r;
  endtask
  // Apply a fault, collect edge pulses and the level held meanwhile
  task trig(input logic [4:0] r, input logic [2:0] ee, input logic [2:0] el);
    logic [2:0] seen;
    seen = 3'b000;
    setq(r);
    repeat (6) begin
      @(negedge clk);
      seen = seen | edge_brake;
    end
    chk("edge_brake", 32'(seen), 32'(ee));
    chk("level_brake", 32'(level_brake), 32'(el));
    setq(5'h00);
    wt(6);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [1:0] c;
    {rst, cyc, stb, we, unl, adr, sel, dat, req} <= {1'b1, 53'h0};
    failures = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(8'hc4 + 8'(4 * i), 32'h0);
    rdc(8'he4, 32'h0);
    $display("test reset done");
    wr(`PBSC_OFF_CTL01, '1);
    rdc(`PBSC_OFF_CTL01, 32'h0);
    unl <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'hc8 + 8'(4 * i), '1);
      rdc(8'hc8 + 8'(4 * i), `PBSC_CTL_MASK);
      wr(8'hc8 + 8'(4 * i), 32'h0);
    end
    wr(`PBSC_OFF_FAIL, '1);
    rdc(`PBSC_OFF_FAIL, `PBSC_FAIL_MASK);
    $display("test protect done");
    // Same code on both channels, so drive enable and level show per code
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr(`PBSC_OFF_CTL01, {12'h0, c, c, 16'h1000});
      setq(5'h01);
      wt(4);
      chk("level0", 32'(level_brake[0]), 32'h1);
      chk("ovr", 32'(chan_override[1:0]), {30'h0, {2{c != 2'b00}}});
      if (c != 2'b00) chk("drv_en", 32'(chan_drive_en[1:0]), {30'h0, {2{c[1]}}});
      if (c[1]) chk("lvl", 32'(chan_level[1:0]), {30'h0, {2{c[0]}}});
      setq(5'h00);
      wt(4);
    end
    wr(`PBSC_OFF_CTL01, 32'h000b_1000);
    setq(5'h01);
    wt(4);
    chk("lvl mix", 32'(chan_level[1:0]), 32'h1);
    setq(5'h00);
    wr(`PBSC_OFF_CTL01, 32'h0);
    wr(`PBSC_OFF_CTL23, 32'h2000);
    trig(5'h02, 3'b000, 3'b010);
    trig(5'h01, 3'b000, 3'b000);
    wr(`PBSC_OFF_INV, 32'h2);
    wt(4);
    chk("inv", 32'(level_brake), 32'h2);
    wr(`PBSC_OFF_INV, 32'h0);
    $display("test level done");
    wr(`PBSC_OFF_CTL01, 32'h10);
    wr(`PBSC_OFF_CTL23, 32'h20);
    wr(`PBSC_OFF_CTL45, 32'h80);
    trig(5'h01, 3'b001, 3'b000);
    trig(5'h02, 3'b010, 3'b000);
    trig(5'h04, 3'b100, 3'b000);
    // Only one detector enabled at a time; a neighbour must stay silent
    for (int i = 0; i < 3; i++) begin
      wr(`PBSC_OFF_FAIL, (i == 0) ? 32'h8 : (i == 1) ? 32'h2 : 32'h1);
      trig(5'(4 << i), 3'b100, 3'b000);
      trig(5'(4 << ((i + 1) % 3)), 3'b000, 3'b000);
    end
    wr(`PBSC_OFF_FAIL, 32'hb);
    wr(`PBSC_OFF_CTL45, 32'h8000);
    trig(5'h10, 3'b000, 3'b100);
    $display("test edge done");
    wr(`PBSC_OFF_CLR, 32'h3f);
    rdc(`PBSC_OFF_STS, 32'h0);
    wr(`PBSC_OFF_IEN, 32'h8);
    chk("irq idle", 32'(irq), 32'h0);
    trig(5'h01, 3'b001, 3'b000);
    rdc(`PBSC_OFF_STS, 32'h8);
    chk("irq set", 32'(irq), 32'h1);
    wr(`PBSC_OFF_IEN, 32'h0);
    chk("irq mask", 32'(irq), 32'h0);
    wr(`PBSC_OFF_IEN, 32'h8);
    chk("irq unmask", 32'(irq), 32'h1);
    wr(`PBSC_OFF_CLR, 32'h8);
    rdc(`PBSC_OFF_STS, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    $display("test irq done");
    unl <= 1'b0;
    bus(1'b1, `PBSC_OFF_SWBRK, 32'h100, 4'h2);
    wt(3);
    rdc(`PBSC_OFF_STS, 32'h0);
    unl <= 1'b1;
    bus(1'b1, `PBSC_OFF_SWBRK, 32'h100, 4'h2);
    wt(3);
    rdc(`PBSC_OFF_STS, 32'h1);
    $display("test swtrig done");
    end_sim;
  end
endmodule // pbsc_top_bench
